//--- spi_dac_adc_defs.vh
// Constants for the serial command logic of the converter channel block.
// Assumes it is included by its bare name from the design files.
`ifndef SPI_DAC_ADC_DEFS_VH
`define SPI_DAC_ADC_DEFS_VH

// Frame and word geometry.
`define WORD_BITS 16
`define BIT_COUNT_BITS 5
`define CHANNELS 8
`define CHANNEL_BITS 3
`define DATA_BITS 12

// Command word fields.
`define CMD_DATA_FLAG 15
`define CMD_ADDR_HI 14
`define CMD_ADDR_LO 11
`define CMD_CH_HI 14
`define CMD_CH_LO 12
`define CMD_DATA_HI 11
`define CMD_DATA_LO 0
`define CMD_PINS_HI 7
`define CMD_PINS_LO 0

// Control register address field values.
`define ADDR_READBACK 4'h1
`define ADDR_SEQUENCE 4'h2
`define ADDR_PIN_SELECT 4'h5
`define ADDR_LOAD_MODE 4'h7

// Readback control fields.
`define RB_EN_HI 4
`define RB_EN_LO 3
`define RB_EN_ON 2'h3
`define RB_CH_HI 2
`define RB_CH_LO 0

// Sequence register fields.
`define SEQ_REPEAT 9
`define SEQ_TEMP 8

// Load mode field and its encodings.
`define LOAD_HI 1
`define LOAD_LO 0
`define LOAD_AUTO 2'h0
`define LOAD_HOLD 2'h1
`define LOAD_ALL 2'h2

// Reset values.
`define PIN_SELECT_RESET 8'h00
`define LOAD_MODE_RESET 2'h0
`define DAC_DATA_RESET 12'h000

// Command buffer depth.
`define FIFO_DEPTH 8
`define FIFO_PTR_BITS 3

`endif

//--- word_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/100ps

module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter PTR_BITS = 3
) (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_BITS-1:0] wr_ptr;
  reg [PTR_BITS-1:0] rd_ptr;
  reg [PTR_BITS:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[PTR_BITS:0]);
  assign out_valid = (count != {(PTR_BITS+1){1'b0}});
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= {PTR_BITS{1'b0}};
      rd_ptr <= {PTR_BITS{1'b0}};
      count <= {(PTR_BITS+1){1'b0}};
    end else if (clk_en) begin
      if (push) begin
        store[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // word_fifo

//--- spi_dac_adc_channel_control.v
// Serial command interpreter for an eight-channel DAC/ADC converter.
// Assumes frame select, serial clock and serial data arrive asynchronously
// from an external host, and that the converter core runs on core_clk.
`timescale 1ns/100ps
`include "spi_dac_adc_defs.vh"

module spi_dac_adc_channel_control (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire frame_sel_n,
  input wire serial_clk,
  input wire serial_in,
  output wire serial_out,
  output wire serial_out_oe_n,
  input wire write_all_enable,
  input wire busy_indicator_enable,
  output wire busy_pin,
  output wire busy_pin_oe_n,
  output reg [7:0] analog_output_pin_bits,
  output wire [95:0] analog_output_levels,
  output reg [1:0] output_load_mode,
  output reg [7:0] analog_input_channel_bits,
  output reg sequence_repeat,
  output reg sequence_temp,
  output reg sequence_active,
  output reg conv_start,
  output reg [2:0] conv_channel,
  input wire conv_done,
  input wire [11:0] conv_result,
  output reg word_dropped
);

  // Two-stage synchronisers plus one history stage for edge detection.
  reg [1:0] sync_sel;
  reg [1:0] sync_clk;
  reg [1:0] sync_din;
  reg sel_last;
  reg clk_last;
  wire sel_fall;
  wire sel_rise;
  wire clk_rise;
  wire clk_fall;

  always @(posedge core_clk) begin
    if (reset) begin
      sync_sel <= 2'h3;
      sync_clk <= 2'h0;
      sync_din <= 2'h0;
      sel_last <= 1'b1;
      clk_last <= 1'b0;
    end else if (clk_en) begin
      sync_sel <= {sync_sel[0], frame_sel_n};
      sync_clk <= {sync_clk[0], serial_clk};
      sync_din <= {sync_din[0], serial_in};
      sel_last <= sync_sel[1];
      clk_last <= sync_clk[1];
    end
  end

  assign sel_fall = sel_last && !sync_sel[1];
  assign sel_rise = !sel_last && sync_sel[1];
  assign clk_rise = !sync_sel[1] && !clk_last && sync_clk[1];
  assign clk_fall = !sync_sel[1] && clk_last && !sync_clk[1];

  // Receive and transmit shifters.
  reg [15:0] rx_shift;
  reg [4:0] rx_count;
  reg [15:0] tx_shift;
  reg tx_drive;
  wire fifo_in_ready;
  wire [15:0] cmd_word;
  wire cmd_valid;
  wire cmd_ready;
  wire frame_done;

  assign frame_done = sel_rise && (rx_count == 5'h10);

  // Input and output register banks of the analog outputs.
  reg [11:0] dac_input [0:7];
  reg [11:0] dac_output [0:7];

  // Readback state.
  reg readback_enable;
  reg [2:0] readback_channel;

  // Sequence state.
  reg [2:0] seq_next;
  reg result_pending;
  reg result_ready;
  reg [2:0] result_channel;
  reg [11:0] result_data;
  reg converting;
  reg stop_after_result;

  // Lowest selected channel at or above a start index, with found flag.
  function [3:0] find_from;
    input [7:0] mask;
    input [3:0] start;
    integer i;
    reg found;
    reg [2:0] idx;
    begin
      found = 1'b0;
      idx = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (mask[i] && (i >= start)) begin
          found = 1'b1;
          idx = i[2:0];
        end
      end
      find_from = {found, idx};
    end
  endfunction

  wire [3:0] seq_after;
  wire [3:0] seq_first;
  assign seq_after = find_from(analog_input_channel_bits,
                               {1'b0, seq_next} + 4'h1);
  assign seq_first = find_from(analog_input_channel_bits, 4'h0);

  always @(posedge core_clk) begin
    if (reset) begin
      rx_shift <= 16'h0000;
      rx_count <= 5'h00;
      tx_shift <= 16'h0000;
      tx_drive <= 1'b0;
      word_dropped <= 1'b0;
    end else if (clk_en) begin
      word_dropped <= frame_done && !fifo_in_ready;
      if (sel_fall) begin
        rx_count <= 5'h00;
        tx_drive <= 1'b0;
        if (sequence_active && result_pending && result_ready) begin
          tx_shift <= {1'b0, result_channel, result_data};
          tx_drive <= 1'b1;
        end else if (sequence_active) begin
          // The first frame of a sequence has no result to return.
          tx_shift <= 16'h0000;
          tx_drive <= 1'b1;
        end else if (readback_enable) begin
          tx_shift <= {1'b1, readback_channel,
                       dac_input[readback_channel]};
          tx_drive <= 1'b1;
        end
      end else if (sel_rise) begin
        tx_drive <= 1'b0;
      end else begin
        if (clk_rise && (rx_count != 5'h10)) begin
          rx_shift <= {rx_shift[14:0], sync_din[1]};
          rx_count <= rx_count + 5'h01;
        end
        if (clk_fall) begin
          tx_shift <= {tx_shift[14:0], 1'b0};
        end
      end
    end
  end

  assign serial_out = tx_shift[15];
  assign serial_out_oe_n = !(tx_drive && !sync_sel[1]);

  word_fifo #(
    .WIDTH(`WORD_BITS),
    .DEPTH(`FIFO_DEPTH),
    .PTR_BITS(`FIFO_PTR_BITS)
  ) cmd_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_data(rx_shift),
    .in_valid(frame_done),
    .in_ready(fifo_in_ready),
    .out_data(cmd_word),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready)
  );

  // Broadcast writes walk the eight channels one per cycle and stall the
  // command stream meanwhile.
  reg bcast_busy;
  reg [2:0] bcast_index;
  reg [11:0] bcast_data;
  wire cmd_take;
  wire is_data;
  wire [3:0] cmd_addr;
  wire [2:0] cmd_channel;
  wire [11:0] cmd_value;
  wire [1:0] cmd_mode;

  assign cmd_ready = !bcast_busy;
  assign cmd_take = cmd_valid && cmd_ready;
  assign is_data = cmd_word[`CMD_DATA_FLAG];
  assign cmd_addr = cmd_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
  assign cmd_channel = cmd_word[`CMD_CH_HI:`CMD_CH_LO];
  assign cmd_value = cmd_word[`CMD_DATA_HI:`CMD_DATA_LO];
  assign cmd_mode = cmd_word[`LOAD_HI:`LOAD_LO];

  integer k;

  always @(posedge core_clk) begin
    if (reset) begin
      analog_output_pin_bits <= `PIN_SELECT_RESET;
      output_load_mode <= `LOAD_MODE_RESET;
      readback_enable <= 1'b0;
      readback_channel <= 3'h0;
      bcast_busy <= 1'b0;
      bcast_index <= 3'h0;
      bcast_data <= `DAC_DATA_RESET;
      for (k = 0; k < `CHANNELS; k = k + 1) begin
        dac_input[k] <= `DAC_DATA_RESET;
        dac_output[k] <= `DAC_DATA_RESET;
      end
    end else if (clk_en) begin
      if (sel_fall && readback_enable && !sequence_active) begin
        // Readback returns one word and then falls back to disabled.
        readback_enable <= 1'b0;
      end
      if (bcast_busy) begin
        if (analog_output_pin_bits[bcast_index]) begin
          dac_input[bcast_index] <= bcast_data;
          if (output_load_mode == `LOAD_AUTO) begin
            dac_output[bcast_index] <= bcast_data;
          end
        end
        bcast_index <= bcast_index + 3'h1;
        if (bcast_index == 3'h7) begin
          bcast_busy <= 1'b0;
        end
      end else if (cmd_take && is_data) begin
        if (write_all_enable) begin
          bcast_busy <= 1'b1;
          bcast_index <= 3'h0;
          bcast_data <= cmd_value;
        end else begin
          dac_input[cmd_channel] <= cmd_value;
          if (output_load_mode == `LOAD_AUTO) begin
            dac_output[cmd_channel] <= cmd_value;
          end
        end
      end else if (cmd_take && (cmd_addr == `ADDR_PIN_SELECT)) begin
        analog_output_pin_bits <=
          cmd_word[`CMD_PINS_HI:`CMD_PINS_LO];
      end else if (cmd_take && (cmd_addr == `ADDR_READBACK)) begin
        readback_enable <=
          (cmd_word[`RB_EN_HI:`RB_EN_LO] == `RB_EN_ON);
        readback_channel <= cmd_word[`RB_CH_HI:`RB_CH_LO];
      end else if (cmd_take && (cmd_addr == `ADDR_LOAD_MODE)) begin
        if (cmd_mode == `LOAD_ALL) begin
          for (k = 0; k < `CHANNELS; k = k + 1) begin
            dac_output[k] <= dac_input[k];
          end
          // Stored mode is left as it was, so 01 comes back as 01.
        end else if (cmd_mode == `LOAD_AUTO || cmd_mode == `LOAD_HOLD) begin
          output_load_mode <= cmd_mode;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CHANNELS; g = g + 1) begin : level_out
      assign analog_output_levels[g*12 +: 12] = dac_output[g];
    end
  endgenerate

  // Conversion sequencer.
  wire seq_write;
  wire [3:0] seq_cmd_first;
  assign seq_write = cmd_take && !is_data && (cmd_addr == `ADDR_SEQUENCE);
  assign seq_cmd_first = find_from(cmd_word[7:0], 4'h0);

  always @(posedge core_clk) begin
    if (reset) begin
      analog_input_channel_bits <= 8'h00;
      sequence_repeat <= 1'b0;
      sequence_temp <= 1'b0;
      sequence_active <= 1'b0;
      seq_next <= 3'h0;
      result_pending <= 1'b0;
      result_ready <= 1'b0;
      result_channel <= 3'h0;
      result_data <= 12'h000;
      converting <= 1'b0;
      stop_after_result <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      if (conv_done && converting) begin
        converting <= 1'b0;
        result_ready <= 1'b1;
        result_data <= conv_result;
      end
      if (seq_write) begin
        analog_input_channel_bits <= cmd_word[7:0];
        sequence_repeat <= cmd_word[`SEQ_REPEAT];
        sequence_temp <= cmd_word[`SEQ_TEMP];
        sequence_active <= (cmd_word[7:0] != 8'h00);
        seq_next <= seq_cmd_first[2:0];
        result_pending <= 1'b0;
        stop_after_result <= 1'b0;
      end else if (sel_fall && sequence_active) begin
        if (stop_after_result) begin
          // Last result goes out in this frame; the converter then idles and floats.
          sequence_active <= 1'b0;
          result_pending <= 1'b0;
        end else begin
          conv_start <= 1'b1;
          conv_channel <= seq_next;
          converting <= 1'b1;
          result_ready <= 1'b0;
          result_pending <= 1'b1;
          result_channel <= seq_next;
          if (seq_after[3]) begin
            seq_next <= seq_after[2:0];
          end else if (sequence_repeat) begin
            seq_next <= seq_first[2:0];
          end else begin
            stop_after_result <= 1'b1;
          end
        end
      end
    end
  end

  // Busy indicator on pin 7: low during a conversion, high otherwise.
  assign busy_pin = !converting;
  assign busy_pin_oe_n = !busy_indicator_enable;

endmodule // spi_dac_adc_channel_control

//--- spi_ctrl_props.sv
// Timing checks on the ports of the serial command interpreter.
// Assumes clk_en is held high and reset is synchronous, active high.
`timescale 1ns/100ps

module spi_ctrl_props (
  input wire core_clk,
  input wire reset,
  input wire frame_sel_n,
  input wire serial_out_oe_n,
  input wire busy_indicator_enable,
  input wire busy_pin,
  input wire busy_pin_oe_n,
  input wire [1:0] output_load_mode,
  input wire [7:0] analog_input_channel_bits,
  input wire sequence_active,
  input wire conv_start,
  input wire [2:0] conv_channel,
  input wire conv_done
);
  // Cycles since the frame select pin went high, saturating.
  reg [3:0] sel_high_cycles;

  always @(posedge core_clk) begin
    if (reset || !frame_sel_n) begin
      sel_high_cycles <= 4'h0;
    end else if (sel_high_cycles != 4'hf) begin
      sel_high_cycles <= sel_high_cycles + 4'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_reset_idle: assert property (
    $fell(reset) |-> serial_out_oe_n && busy_pin && !conv_start
      && output_load_mode == 2'h0 && !sequence_active)
    else $error("state after reset not idle");
  a_oe_in_frame: assert property (
    !serial_out_oe_n |-> sel_high_cycles < 4'h6)
    else $error("serial output driven outside a frame");
  a_mode_legal: assert property (output_load_mode[1] == 1'b0)
    else $error("stored load mode left at a transfer value");
  a_start_in_frame: assert property (
    conv_start |-> !frame_sel_n && sequence_active)
    else $error("conversion started outside a sequence frame");
  a_start_pulse: assert property (conv_start |=> !conv_start [*3])
    else $error("conversion start longer than one cycle");
  a_chan_selected: assert property (
    conv_start |-> analog_input_channel_bits[conv_channel])
    else $error("conversion on a channel not in the sequence");
  a_busy_falls: assert property (conv_start |-> ##[1:2] !busy_pin)
    else $error("busy indicator not low during conversion");
  a_busy_rises: assert property (
    conv_done && !conv_start |-> ##[1:2] busy_pin)
    else $error("busy indicator not high after result");
  a_busy_oe: assert property (
    busy_pin_oe_n == !busy_indicator_enable)
    else $error("busy pin enable wrong");
endmodule // spi_ctrl_props

//--- spi_host_model.sv
// Serial host that frames 16-bit words for the command interpreter.
// Assumes the bench calls xfer from its own process on core_clk.
`timescale 1ns/100ps

module spi_host_model (
  input wire core_clk,
  input wire serial_out,
  input wire serial_out_oe_n,
  output reg frame_sel_n,
  output reg serial_clk,
  output reg serial_in
);
  reg last;
  // A released line is shown as the inverse of its last value.
  wire line = serial_out_oe_n ? ~last : serial_out;

  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    last = 1'b0;
  end

  // Serial clock period is eight core cycles, four low and four high.
  task xfer(input [15:0] w, output [15:0] r, output drove);
    integer i;
    begin
      drove = 1'b0;
      @(posedge core_clk) frame_sel_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      for (i = 15; i >= 0; i = i - 1) begin
        serial_in <= w[i];
        repeat (4) @(posedge core_clk);
        serial_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        r[i] = line;
        last = line;
        drove = drove | !serial_out_oe_n;
        serial_clk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      frame_sel_n <= 1'b1;
      serial_in <= ~serial_in;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule // spi_host_model

//--- tb_spi_dac_adc_channel_control.sv
// Self-checking bench for the serial command interpreter.
// Assumes the host model and the props checker are compiled before it.
`timescale 1ns/100ps

module tb_spi_dac_adc_channel_control;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg write_all_enable = 1'b0;
  reg busy_indicator_enable = 1'b0;
  reg conv_done = 1'b0;
  reg [11:0] conv_result = 12'h000;
  wire frame_sel_n, serial_clk, serial_in, serial_out, serial_out_oe_n;
  wire busy_pin, busy_pin_oe_n, sequence_repeat, sequence_temp;
  wire sequence_active, conv_start, word_dropped;
  wire [7:0] analog_output_pin_bits, analog_input_channel_bits;
  wire [95:0] analog_output_levels;
  wire [1:0] output_load_mode;
  wire [2:0] conv_channel;
  integer err_total = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer i;
  reg [15:0] rx;
  reg drove;
  reg [11:0] exp_lv [0:7];
  reg [3:0] conv_cnt = 4'h0;
  reg [2:0] conv_ch = 3'h0;
  reg [7:0] n_dropped = 8'h00;

  always #12.5 core_clk = ~core_clk;

  spi_dac_adc_channel_control dut (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .write_all_enable(write_all_enable),
    .busy_indicator_enable(busy_indicator_enable), .busy_pin(busy_pin),
    .busy_pin_oe_n(busy_pin_oe_n),
    .analog_output_pin_bits(analog_output_pin_bits),
    .analog_output_levels(analog_output_levels),
    .output_load_mode(output_load_mode),
    .analog_input_channel_bits(analog_input_channel_bits),
    .sequence_repeat(sequence_repeat), .sequence_temp(sequence_temp),
    .sequence_active(sequence_active), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_result(conv_result), .word_dropped(word_dropped)
  );

  spi_host_model host (
    .core_clk(core_clk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in)
  );

  // Converter core stand-in: result is 12'h5a0 plus the channel index.
  always @(posedge core_clk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      conv_cnt <= 4'h6;
      conv_ch <= conv_channel;
    end else if (conv_cnt != 4'h0) begin
      conv_cnt <= conv_cnt - 4'h1;
    end
    if (conv_cnt == 4'h1) begin
      conv_done <= 1'b1;
      conv_result <= 12'h5a0 + {9'h000, conv_ch};
    end
  end

  // Counts dropped words; no scenario sends fast enough to fill the buffer.
  always @(posedge core_clk) begin
    if (!reset && word_dropped !== 1'b0) n_dropped <= n_dropped + 8'h01;
  end

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      test_done;
    end
  end

  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task chk_lv;
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1) begin
        chk({4'h0, analog_output_levels[12*j +: 12]}, {4'h0, exp_lv[j]});
      end
    end
  endtask

  // One framed word, then room for decode and a write-all stall.
  task send(input [15:0] w);
    begin
      host.xfer(w, rx, drove);
      repeat (10) @(posedge core_clk);
    end
  endtask

  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(serial_out_oe_n, 1'b1);
    chk(output_load_mode, 2'h0);
    for (i = 0; i < 8; i = i + 1) exp_lv[i] = 12'h000;
    chk_lv;
    send(16'h28a5);
    chk(analog_output_pin_bits, 8'ha5);
    for (i = 0; i < 8; i = i + 1) begin
      exp_lv[i] = 12'h0c0 + 12'h210 * i;
      send({1'b1, i[2:0], exp_lv[i]});
    end
    chk_lv;
    $display("dac write test done");

    send(16'h3801);
    send(16'ha777);
    send(16'hd5e5);
    chk_lv;
    send(16'h081d);
    send(16'h0000);
    chk(rx, 16'hd5e5);
    send(16'h0815);
    send(16'h0000);
    chk(drove, 1'b0);
    send(16'h3802);
    exp_lv[2] = 12'h777;
    exp_lv[5] = 12'h5e5;
    chk_lv;
    chk(output_load_mode, 2'h1);
    send(16'h3803);
    chk(output_load_mode, 2'h1);
    $display("load mode test done");

    send(16'h3800);
    write_all_enable <= 1'b1;
    send(16'h8123);
    for (i = 0; i < 8; i = i + 1) if (i == 0 || i == 2 || i == 5 || i == 7)
      exp_lv[i] = 12'h123;
    chk_lv;
    write_all_enable <= 1'b0;
    $display("write all test done");

    busy_indicator_enable <= 1'b1;
    send(16'h100a);
    chk(drove, 1'b0);
    repeat (20) @(posedge core_clk);
    send(16'h0000);
    send(16'h0000);
    chk(rx, 16'h15a1);
    send(16'h0000);
    chk(rx, 16'h35a3);
    send(16'h0000);
    chk(drove, 1'b0);
    chk(sequence_active, 1'b0);
    $display("single sequence test done");

    send(16'h1204);
    chk(sequence_repeat, 1'b1);
    chk(sequence_temp, 1'b0);
    repeat (20) @(posedge core_clk);
    send(16'h0000);
    for (i = 0; i < 2; i = i + 1) begin
      send(16'h0000);
      chk(rx, 16'h25a2);
    end
    send(16'h1000);
    send(16'h0000);
    chk(sequence_active, 1'b0);
    chk({8'h00, n_dropped}, 16'h0000);
    $display("repeat sequence test done");
    test_done;
  end
endmodule // tb_spi_dac_adc_channel_control

bind spi_dac_adc_channel_control spi_ctrl_props u_props (
  .core_clk(core_clk), .reset(reset), .frame_sel_n(frame_sel_n),
  .serial_out_oe_n(serial_out_oe_n),
  .busy_indicator_enable(busy_indicator_enable), .busy_pin(busy_pin),
  .busy_pin_oe_n(busy_pin_oe_n), .output_load_mode(output_load_mode),
  .analog_input_channel_bits(analog_input_channel_bits),
  .sequence_active(sequence_active), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_done(conv_done)
);
